// file: rtl/uhpc_pipe_config.sv
// USB host pipe configuration, byte count and token pacing with APB registers
module uhpc_pipe_config #(
  parameter logic [12:0] DPRAM_BYTES   = 13'h1000,
  parameter logic [1:0]  MAX_BK_CODE   = 2'h2,
  parameter logic [2:0]  MAX_SIZE_CODE = 3'h7
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [uhpc_pkg::AW-1:0]        paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           high_speed,
  input  wire logic                           uframe_tick,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     sw_byte_wr,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     sw_byte_rd,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     usb_byte_tx,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     usb_byte_rx,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     usb_ack,
  input  wire logic [uhpc_pkg::NPIPE-1:0]     usb_pkt_done,
  output uhpc_pkg::uhpc_pipe_out_t [uhpc_pkg::NPIPE-1:0] pipe_out,
  output logic                                usb_reset_req
);
  import uhpc_pkg::*;

  typedef struct packed {
    logic [NPIPE-1:0]                  on;
    logic [NPIPE-1:0]                  clr;
    uhpc_cfg_t [NPIPE-1:0]             cfg;
    logic [NPIPE-1:0][6:0]             addr;
    logic [NPIPE-1:0][10:0]            cnt;
    logic [NPIPE-1:0]                  tog;
    logic [NPIPE-1:0]                  valid;
    logic [NPIPE-1:0]                  acked;
    logic [NPIPE-1:0][7:0]             ivl;
    uhpc_pipe_out_t [NPIPE-1:0]        po;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    logic                              usb_reset_req;
  } uhpc_state_t;

  uhpc_state_t st;
  uhpc_state_t next_st;

  // Bytes taken in the DPRAM by one pipe layout
  function automatic logic [12:0] layout_bytes(uhpc_cfg_t c);
    logic [12:0] cap;
    cap = 13'(BANK_MIN_BYTES << c.bank_size_code);
    unique case (c.bank_count_code)
      2'h0:    return cap;
      2'h1:    return 13'(cap << 1);
      default: return 13'((cap << 1) + cap);
    endcase
  endfunction

  always_comb begin
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;
    logic [11:0] co;
    logic [11:0] so;
    logic [2:0]  ci;
    logic [2:0]  si;
    logic        bus_rst;
    uhpc_cfg_t   wc;
    logic [13:0] used;
    logic        fits;
    logic        use_ok;
    logic        out_dir;
    logic        in_dir;
    logic        inc;
    logic        dec;
    logic        bulkish;
    logic        need;
    logic        fire;
    logic [10:0] cap;
    acc     = psel & penable & st.pready;
    wr      = acc & pwrite;
    hit     = 1'b0;
    rd      = 32'h0000_0000;
    co      = paddr - OFS_CFG;
    so      = paddr - OFS_STATE;
    ci      = co[4:2];
    si      = so[4:2];
    bus_rst = 1'b0;
    wc      = uhpc_cfg_t'(pwdata & CFG_WMASK);
    used    = 14'h0000;
    fits    = 1'b0;
    use_ok  = 1'b0;
    out_dir = 1'b0;
    in_dir  = 1'b0;
    inc     = 1'b0;
    dec     = 1'b0;
    bulkish = 1'b0;
    need    = 1'b0;
    fire    = 1'b0;
    cap     = 11'h000;
    next_st = st;
    next_st.usb_reset_req = 1'b0;

    // Read decode and one wait state before the answer
    if (paddr == OFS_PIPE_EN_RST) begin
      hit = 1'b1;
      rd[ON_LSB +: NPIPE]  = st.on;
      rd[CLR_LSB +: NPIPE] = st.clr;
    end else if (paddr == OFS_ADDR_LO || paddr == OFS_ADDR_HI) begin
      hit = 1'b1;
      for (int k = 0; k < 4; k++) begin
        rd[k*8 +: 7] = (paddr == OFS_ADDR_LO) ? st.addr[k] : st.addr[k+4];
      end
    end else if (co < PIPE_SPAN) begin
      hit = 1'b1;
      rd  = 32'(st.cfg[ci]);
    end else if (so < PIPE_SPAN) begin
      hit = 1'b1;
      rd[CNT_LSB +: 11]  = st.cnt[si];
      rd[VALID_BIT]      = st.valid[si];
      rd[ALLOWED_BIT]    = st.po[si].fifo_access_allowed;
      rd[TOG_BIT]        = st.tog[si];
    end else if (paddr == OFS_HOST_CTRL) begin
      hit = 1'b1;
    end
    if (psel & penable & ~st.pready) begin
      next_st.pready  = 1'b1;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd;
      next_st.pslverr = ~hit;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // Register writes land on the completing edge
    if (wr && paddr == OFS_HOST_CTRL && pwdata[BUS_RST_BIT]) begin
      bus_rst = 1'b1;
      next_st.usb_reset_req = 1'b1;
    end
    if (wr && (paddr == OFS_ADDR_LO || paddr == OFS_ADDR_HI)) begin
      for (int k = 0; k < 4; k++) begin
        if (paddr == OFS_ADDR_LO) begin
          next_st.addr[k] = pwdata[k*8 +: 7];
        end else begin
          next_st.addr[k+4] = pwdata[k*8 +: 7];
        end
      end
    end
    if (wr && paddr == OFS_PIPE_EN_RST) begin
      next_st.on  = pwdata[ON_LSB +: NPIPE];
      next_st.clr = pwdata[CLR_LSB +: NPIPE];
    end

    for (int n = 0; n < NPIPE; n++) begin
      // Configuration write and layout check
      if (wr && co < PIPE_SPAN && ci == 3'(n)) begin
        next_st.cfg[n] = wc;
        if (wc.bank_memory_claim) begin
          used = 14'h0000;
          for (int m = 0; m < NPIPE; m++) begin
            if (m != n && st.cfg[m].bank_memory_claim && st.valid[m]) begin
              used = 14'(used + layout_bytes(st.cfg[m]));
            end
          end
          used = 14'(used + layout_bytes(wc));
          fits = (wc.bank_count_code <= MAX_BK_CODE) &&
                 (wc.bank_count_code != BK_RSV) &&
                 (wc.token_kind != TOK_RSV) &&
                 (wc.bank_size_code <= MAX_SIZE_CODE) &&
                 (used <= {1'b0, DPRAM_BYTES});
          next_st.valid[n] = fits;
        end else begin
          next_st.valid[n] = 1'b0;
        end
      end

      // Byte counting per direction
      use_ok  = st.on[n] & ~st.clr[n] & st.valid[n] & st.cfg[n].bank_memory_claim;
      out_dir = st.cfg[n].token_kind == TOK_OUT || st.cfg[n].token_kind == TOK_SETUP;
      in_dir  = st.cfg[n].token_kind == TOK_IN;
      inc     = use_ok & ((out_dir & sw_byte_wr[n]) | (in_dir & usb_byte_rx[n]));
      dec     = use_ok & ((out_dir & usb_byte_tx[n]) | (in_dir & sw_byte_rd[n]));
      if (inc & ~dec) begin
        next_st.cnt[n] = 11'(st.cnt[n] + 11'h001);
      end else if (dec & ~inc & (st.cnt[n] != 11'h000)) begin
        next_st.cnt[n] = 11'(st.cnt[n] - 11'h001);
      end

      // Token pacing for bulk and control OUT traffic
      bulkish = st.cfg[n].transfer_kind == KIND_BULK ||
                st.cfg[n].transfer_kind == KIND_CTRL;
      need    = use_ok & bulkish & (st.cfg[n].token_kind == TOK_OUT) &
                (st.cnt[n] != 11'h000) & ~st.acked[n];
      fire    = 1'b0;
      if (st.cfg[n].poll_period_ms == 8'h00) begin
        fire = need;
      end else if (need & uframe_tick) begin
        if (8'(st.ivl[n] + 8'h01) >= st.cfg[n].poll_period_ms) begin
          fire = 1'b1;
          next_st.ivl[n] = 8'h00;
        end else begin
          next_st.ivl[n] = 8'(st.ivl[n] + 8'h01);
        end
      end else if (~need) begin
        next_st.ivl[n] = 8'h00;
      end
      // Ack wins over the release by an empty FIFO
      next_st.acked[n] = usb_ack[n] | (st.acked[n] & (st.cnt[n] != 11'h000));
      next_st.tog[n]   = st.tog[n] ^ usb_pkt_done[n];

      // Pipe clear: machinery reset, toggle kept
      if (next_st.clr[n]) begin
        next_st.cnt[n]   = 11'h000;
        next_st.acked[n] = 1'b0;
        next_st.ivl[n]   = 8'h00;
        fire             = 1'b0;
      end
      // Disable: keep only claim, bank count and size
      if (~next_st.on[n]) begin
        next_st.cfg[n] = CFG_RST;
        next_st.cfg[n].bank_memory_claim = st.cfg[n].bank_memory_claim;
        next_st.cfg[n].bank_count_code   = st.cfg[n].bank_count_code;
        next_st.cfg[n].bank_size_code    = st.cfg[n].bank_size_code;
        if (wr && co < PIPE_SPAN && ci == 3'(n)) begin
          next_st.cfg[n].bank_memory_claim = wc.bank_memory_claim;
          next_st.cfg[n].bank_count_code   = wc.bank_count_code;
          next_st.cfg[n].bank_size_code    = wc.bank_size_code;
        end
        next_st.cnt[n]   = 11'h000;
        next_st.tog[n]   = 1'b0;
        next_st.acked[n] = 1'b0;
        next_st.ivl[n]   = 8'h00;
        fire             = 1'b0;
      end
      // USB bus reset clears the listed settings
      if (bus_rst) begin
        next_st.addr[n] = 7'h00;
        next_st.cfg[n].poll_period_ms      = 8'h00;
        next_st.cfg[n].ping_enable         = 1'b0;
        next_st.cfg[n].target_endpoint_num = 4'h0;
        next_st.cfg[n].transfer_kind       = KIND_CTRL;
        next_st.cfg[n].auto_bank_flip      = 1'b0;
        next_st.cfg[n].bank_size_code      = 3'h0;
        next_st.cfg[n].bank_count_code     = 2'h0;
        next_st.cfg[n].bank_memory_claim   = 1'b0;
        next_st.valid[n] = 1'b0;
        next_st.acked[n] = 1'b0;
        fire             = 1'b0;
      end

      // Registered per-pipe view for the transfer engine
      cap = 11'(BANK_MIN_BYTES << next_st.cfg[n].bank_size_code);
      use_ok = next_st.on[n] & ~next_st.clr[n] & next_st.valid[n] &
               next_st.cfg[n].bank_memory_claim;
      next_st.po[n].usable = use_ok;
      if (next_st.cfg[n].token_kind == TOK_IN) begin
        next_st.po[n].fifo_access_allowed = use_ok & (next_st.cnt[n] != 11'h000);
      end else begin
        next_st.po[n].fifo_access_allowed = use_ok & (next_st.cnt[n] < cap);
      end
      next_st.po[n].token_req = fire;
      bulkish = next_st.cfg[n].transfer_kind == KIND_BULK ||
                next_st.cfg[n].transfer_kind == KIND_CTRL;
      next_st.po[n].ping = next_st.cfg[n].ping_enable & high_speed & bulkish &
                           (next_st.cfg[n].token_kind == TOK_OUT);
      next_st.po[n].token       = next_st.cfg[n].token_kind;
      next_st.po[n].kind        = next_st.cfg[n].transfer_kind;
      next_st.po[n].endpoint    = next_st.cfg[n].target_endpoint_num;
      next_st.po[n].target_addr = next_st.addr[n];
      next_st.po[n].poll_ms = (next_st.cfg[n].transfer_kind == KIND_INTR) ?
                              next_st.cfg[n].poll_period_ms : 8'h00;
      next_st.po[n].toggle    = next_st.tog[n];
      next_st.po[n].auto_flip = next_st.cfg[n].auto_bank_flip;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st     <= '0;
      st.on  <= ON_RST;
      st.clr <= CLR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign pipe_out      = st.po;
  assign usb_reset_req = st.usb_reset_req;
endmodule

// file: pkg/uhpc_pkg.sv
// Constants and types of the USB host pipe configuration block
package uhpc_pkg;
  localparam int          NPIPE           = 8;
  localparam int          AW              = 12;
  localparam logic [11:0] OFS_PIPE_EN_RST = 12'h41c;
  localparam logic [11:0] OFS_ADDR_LO     = 12'h424;
  localparam logic [11:0] OFS_ADDR_HI     = 12'h428;
  localparam logic [11:0] OFS_CFG         = 12'h500;
  localparam logic [11:0] OFS_STATE       = 12'h530;
  localparam logic [11:0] OFS_HOST_CTRL   = 12'h5f0;
  localparam logic [11:0] PIPE_SPAN       = 12'h020;
  localparam int          ON_LSB          = 0;
  localparam int          CLR_LSB         = 16;
  localparam int          CNT_LSB         = 20;
  localparam int          VALID_BIT       = 18;
  localparam int          ALLOWED_BIT     = 16;
  localparam int          TOG_BIT         = 8;
  localparam int          BUS_RST_BIT     = 0;
  localparam logic [31:0] CFG_RST         = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK       = 32'hff1f_377e;
  localparam logic [7:0]  ON_RST          = 8'h00;
  localparam logic [7:0]  CLR_RST         = 8'h00;
  localparam logic [12:0] BANK_MIN_BYTES  = 13'h0008;
  localparam logic [1:0]  BK_RSV          = 2'h3;

  typedef enum logic [1:0] {KIND_CTRL, KIND_ISO, KIND_BULK, KIND_INTR} uhpc_kind_t;
  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT, TOK_RSV} uhpc_tok_t;

  typedef struct packed {
    logic [7:0] poll_period_ms;
    logic [2:0] rsv3;
    logic       ping_enable;
    logic [3:0] target_endpoint_num;
    logic [1:0] rsv2;
    uhpc_kind_t transfer_kind;
    logic       rsv1;
    logic       auto_bank_flip;
    uhpc_tok_t  token_kind;
    logic       rsv0;
    logic [2:0] bank_size_code;
    logic [1:0] bank_count_code;
    logic       bank_memory_claim;
    logic       rsvb;
  } uhpc_cfg_t;

  typedef struct packed {
    logic       usable;
    logic       fifo_access_allowed;
    logic       token_req;
    logic       ping;
    uhpc_tok_t  token;
    uhpc_kind_t kind;
    logic [3:0] endpoint;
    logic [6:0] target_addr;
    logic [7:0] poll_ms;
    logic       toggle;
    logic       auto_flip;
  } uhpc_pipe_out_t;
endpackage

// file: tb/uhpc_pipe_config_monitor.sv
// Checker of APB timing and per-pipe output relations
module uhpc_pipe_config_monitor (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [11:0]                    paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire uhpc_pkg::uhpc_pipe_out_t [7:0] pipe_out,
  input wire logic                           usb_reset_req
);
  import uhpc_pkg::*;
  logic bad_poll;
  logic bad_ping;
  logic bad_tok;
  logic addr_any;
  always_comb begin
    bad_poll = 1'b0;
    bad_ping = 1'b0;
    bad_tok  = 1'b0;
    addr_any = 1'b0;
    for (int i = 0; i < NPIPE; i++) begin
      bad_poll |= pipe_out[i].kind != KIND_INTR && pipe_out[i].poll_ms != 8'h0;
      // Ping only for OUT tokens on control or bulk kinds
      bad_ping |= pipe_out[i].ping && !(pipe_out[i].token == TOK_OUT && !pipe_out[i].kind[0]);
      bad_tok  |= pipe_out[i].token_req && !pipe_out[i].usable;
      addr_any |= pipe_out[i].target_addr != 7'h0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  sequence s_rst_wr; psel && penable && pready && pwrite && paddr == 12'h5f0 && pwdata[0]; endsequence
  property p_wait; s_setup |=> s_answer; endproperty
  a_wait: assert property (p_wait) else $error("ready timing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rst; s_rst_wr |-> ##[1:2] usb_reset_req; endproperty
  a_rst: assert property (p_rst) else $error("bus reset missing");
  property p_addr; usb_reset_req |-> ##[0:2] !addr_any; endproperty
  a_addr: assert property (p_addr) else $error("address kept");
  property p_poll; !bad_poll; endproperty
  a_poll: assert property (p_poll) else $error("poll period leak");
  property p_ping; !bad_ping; endproperty
  a_ping: assert property (p_ping) else $error("ping misuse");
  property p_tok; !bad_tok; endproperty
  a_tok: assert property (p_tok) else $error("token on unusable pipe");
endmodule

// file: tb/uhpc_usb_dev_model.sv
// Attached device model: acknowledges each pipe token after a set delay
module uhpc_usb_dev_model (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire uhpc_pkg::uhpc_pipe_out_t [7:0] pipe_out,
  input wire logic [7:0]                     ack_delay,
  output logic [7:0]                         usb_ack
);
  import uhpc_pkg::*;
  logic [7:0] pend;
  logic [7:0] cnt [8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_ack <= 8'h0;
      pend    <= 8'h0;
      cnt     <= '{default: 8'h0};
    end else begin
      for (int i = 0; i < NPIPE; i++) begin
        if (usb_ack[i]) begin
          usb_ack[i] <= 1'b0;
          pend[i]    <= 1'b0;
        end else if (pend[i] || pipe_out[i].token_req) begin
          pend[i]    <= 1'b1;
          usb_ack[i] <= cnt[i] == ack_delay;
          cnt[i]     <= (cnt[i] == ack_delay) ? 8'h0 : cnt[i] + 8'h1;
        end
      end
    end
  end
endmodule

// file: tb/uhpc_pipe_config_tb_top.sv
// Testbench top of the pipe configuration block
module uhpc_pipe_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uhpc_pkg::*;
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic err;} uhpc_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        high_speed = 1'b1, uframe_tick = 1'b0, pready, pslverr, usb_reset_req, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  sw_byte_wr = 8'h0, sw_byte_rd = 8'h0, usb_byte_tx = 8'h0, usb_byte_rx = 8'h0;
  logic [7:0]  usb_pkt_done = 8'h0, ack_delay = 8'h1e, usb_ack;
  uhpc_pipe_out_t [NPIPE-1:0] pipe_out;
  int          mismatches = 0, comparisons = 0, n, k;
  uhpc_row_t   rows [15] = '{
    '{1'b1, 12'h41c, 32'hff, 32'hff, 1'b0},
    '{1'b1, 12'h424, 32'hffffffff, 32'h7f7f7f7f, 1'b0},
    '{1'b1, 12'h428, 32'h8a8b8c8d, 32'h0a0b0c0d, 1'b0},
    '{1'b1, 12'h500, 32'h00120002, 32'h00120002, 1'b0},
    '{1'b1, 12'h504, 32'h000f1116, 32'h000f1116, 1'b0},
    '{1'b1, 12'h508, 32'h00052672, 32'h00052672, 1'b0},
    '{1'b1, 12'h50c, 32'h40013132, 32'h40013132, 1'b0},
    '{1'b1, 12'h510, 32'he, 32'he, 1'b0},
    '{1'b1, 12'h514, 32'h302, 32'h302, 1'b0},
    '{1'b1, 12'h518, 32'h76, 32'h76, 1'b0},
    '{1'b1, 12'h530, 32'hffffffff, 32'h00050000, 1'b0},
    '{1'b0, 12'h540, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h544, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h548, 32'h0, 32'h00050000, 1'b0},
    '{1'b1, 12'h600, 32'h1, 32'h0, 1'b1}};
  always #20 pclk = ~pclk;
  uhpc_pipe_config uhpc_pipe_config_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_speed(high_speed), .uframe_tick(uframe_tick),
    .sw_byte_wr(sw_byte_wr), .sw_byte_rd(sw_byte_rd), .usb_byte_tx(usb_byte_tx),
    .usb_byte_rx(usb_byte_rx), .usb_ack(usb_ack), .usb_pkt_done(usb_pkt_done),
    .pipe_out(pipe_out), .usb_reset_req(usb_reset_req));
  uhpc_usb_dev_model uhpc_usb_dev_model_inst (.pclk(pclk), .presetn(presetn),
    .pipe_out(pipe_out), .ack_delay(ack_delay), .usb_ack(usb_ack));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("read data", x, rd)
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("pipe view", 0, pipe_out)
    rdchk(12'h41c, 32'h0);
    rdchk(12'h500, 32'h0);
    $display("done reset");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        apb(1'b1, rows[i].a, rows[i].d);
        `CHK("write error", rows[i].err, er)
      end
      rdchk(rows[i].a, rows[i].x);
      `CHK("read error", rows[i].err, er)
    end
    apb(1'b1, 12'h510, 32'h0000000a);
    rdchk(12'h540, 32'h00050000);
    $display("done table");
    repeat (3) begin
      sw_byte_wr <= 8'h04;
      @(posedge pclk);
    end
    sw_byte_wr  <= 8'h0;
    usb_byte_tx <= 8'h04;
    sw_byte_rd  <= 8'h02;
    @(posedge pclk);
    usb_byte_tx <= 8'h0;
    sw_byte_rd  <= 8'h0;
    usb_byte_rx <= 8'h02;
    @(posedge pclk);
    usb_byte_rx <= 8'h0;
    repeat (2) @(posedge pclk);
    `CHK("token level", 1'b1, pipe_out[2].token_req)
    rdchk(12'h538, 32'h00250000);
    rdchk(12'h534, 32'h00150000);
    n = 0;
    while (usb_ack[2] !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) mismatches++;
    repeat (2) @(posedge pclk);
    `CHK("token after ack", 1'b0, pipe_out[2].token_req)
    usb_byte_tx <= 8'h04;
    repeat (2) @(posedge pclk);
    usb_byte_tx <= 8'h0;
    ack_delay   <= 8'h0;
    apb(1'b1, 12'h508, 32'h03052672);
    sw_byte_wr <= 8'h04;
    @(posedge pclk);
    sw_byte_wr <= 8'h0;
    n = 0;
    k = 0;
    while (pipe_out[2].token_req !== 1'b1 && k < 40) begin
      uframe_tick <= k % 4 == 0;
      n += int'(k % 4 == 0);
      k++;
      @(posedge pclk);
    end
    uframe_tick <= 1'b0;
    `CHK("ticks per token", 3, n)
    $display("done count and pacing");
    usb_pkt_done <= 8'h02;
    @(posedge pclk);
    usb_pkt_done <= 8'h0;
    apb(1'b1, 12'h41c, 32'h000200ff);
    `CHK("usable in clear", 1'b0, pipe_out[1].usable)
    `CHK("toggle in clear", 1'b1, pipe_out[1].toggle)
    rdchk(12'h504, 32'h000f1116);
    rdchk(12'h534, 32'h00040100);
    apb(1'b1, 12'h41c, 32'hff);
    `CHK("usable after clear", 1'b1, pipe_out[1].usable)
    apb(1'b1, 12'h41c, 32'hfd);
    `CHK("toggle when off", 1'b0, pipe_out[1].toggle)
    rdchk(12'h504, 32'h16);
    $display("done clear and disable");
    apb(1'b1, 12'h5f0, 32'h1);
    rdchk(12'h5f0, 32'h0);
    rdchk(12'h424, 32'h0);
    rdchk(12'h508, 32'h200);
    $display("done bus reset");
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim;
  end
endmodule
bind uhpc_pipe_config uhpc_pipe_config_monitor uhpc_pipe_config_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pipe_out(pipe_out),
  .usb_reset_req(usb_reset_req));
